// file: gpc_map.svh
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH
// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define GPC_IDX_P21 8'h2c
`define GPC_IDX_P22 8'h2d
`define GPC_IDX_P23 8'h2e
`define GPC_IDX_P24 8'h2f
`define GPC_IDX_P25 8'h30
`define GPC_IDX_P26 8'h31
`define GPC_IDX_P27 8'h32
`define GPC_IDX_P30 8'h33
`define GPC_IDX_P31 8'h34
`define GPC_IDX_DOUT 8'h40
`define GPC_IDX_PINS 8'h41
`define GPC_IDX_STAT 8'h42
`define GPC_IDX_MASK 8'h43
// ------------------------------------------------------------
// Pin slots, in register order
// ------------------------------------------------------------
`define GPC_NPIN 9
`define GPC_NEV 2
`define GPC_S21 0
`define GPC_S22 1
`define GPC_S23 2
`define GPC_S24 3
`define GPC_S25 4
`define GPC_S26 5
`define GPC_S27 6
`define GPC_S30 7
`define GPC_S31 8
// ------------------------------------------------------------
// Config fields, reset value and writable masks
// ------------------------------------------------------------
`define GPC_B_DIR 0
`define GPC_B_POL 1
`define GPC_B_ALT 2
`define GPC_B_FNHI 3
`define GPC_B_OD 7
`define GPC_CFG_RST 8'h01
`define GPC_WM_FN2 8'h8f
`define GPC_WM_FN1 8'h87
`define GPC_WM_NONE 8'h83
`endif

// file: gpc_pkg.sv
package gpc_pkg;
   // ------------------------------------------------------------
   // Two-bit function select codes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      fn_gpio = 2'b00,   // Plain GPIO
      fn_kbc = 2'b01,    // Keyboard controller port bit
      fn_edge = 2'b10,   // Either-edge interrupt input
      fn_extra = 2'b11   // Reserved on 2.1, motor select on 2.2
   } gpc_fn_type;
endpackage : gpc_pkg

// file: gpc_pin_cell.sv
`timescale 1ns/1ps
`include "gpc_map.svh"
// One pad: direction, polarity and driver type around one pin
module gpc_pin_cell (
   // Configuration byte of this pin
   input wire logic [7:0] cfg_i,
   // Value to drive: alternate source or software data
   input wire logic alt_en_i,
   input wire logic alt_val_i,
   input wire logic gpio_val_i,
   // Pad
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_o,
   // Pin level after polarity, as seen by the core
   output logic val_o
);
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire logic is_in = cfg_i[`GPC_B_DIR];     // Input when set
   wire logic inv = cfg_i[`GPC_B_POL];       // Invert both ways
   wire logic od = cfg_i[`GPC_B_OD];         // Open drain
   wire logic src = alt_en_i ? alt_val_i : gpio_val_i;
   wire logic drv = src ^ inv;
   // ------------------------------------------------------------
   // Driver: open drain only ever pulls low, so a high level is
   // left to the board pull-up
   // ------------------------------------------------------------
   assign pin_o = od ? 1'b0 : drv;
   assign pin_oe_o = !is_in && (od ? !drv : 1'b1);
   assign val_o = pin_i ^ inv;
endmodule : gpc_pin_cell

// file: gpc_port_cfg.sv
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "gpc_map.svh"
// ------------------------------------------------------------
// ------------------------------------------------------------
module gpc_port_cfg #(
   parameter int ADR_W = 10
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pads, slot order 2.1 .. 2.7, 3.0, 3.1
   input wire logic [`GPC_NPIN-1:0] pin_i,
   output logic [`GPC_NPIN-1:0] pin_o,
   output logic [`GPC_NPIN-1:0] pin_oe_o,
   // Keyboard controller port bits
   input wire logic kbc_port_bit6_i,
   input wire logic kbc_port_bit2_i,
   input wire logic kbc_port_bit7_i,
   output logic kbc_port_bit6_o,
   output logic kbc_port_bit2_o,
   output logic kbc_port_bit7_o,
   // Other alternate sources and sinks
   input wire logic floppy_motor_select_1_i,
   input wire logic system_mgmt_interrupt_out_i,
   input wire logic ext_bus_chip_select_2_i,
   input wire logic ext_bus_chip_select_3_i,
   output logic irq_input_d_o,
   // Interrupt
   output logic irq_o
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Writable bits of each slot; everything else stays zero
   function automatic logic [7:0] wmask(input int s);
      if (s == `GPC_S21 || s == `GPC_S22) begin
         wmask = `GPC_WM_FN2;
      end else if (s == `GPC_S26) begin
         wmask = `GPC_WM_NONE;
      end else begin
         wmask = `GPC_WM_FN1;
      end
   endfunction : wmask

   // Two-bit function field of a config byte
   function automatic gpc_pkg::gpc_fn_type fn2(input logic [7:0] c);
      fn2 = gpc_pkg::gpc_fn_type'(c[`GPC_B_FNHI:`GPC_B_ALT]);
   endfunction : fn2

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0] cfg_q [`GPC_NPIN];          // Pin configuration
   logic [`GPC_NPIN-1:0] dout_q;           // Software output data
   logic [`GPC_NEV-1:0] stat_q;            // Sticky edge events
   logic [`GPC_NEV-1:0] mask_q;            // Event enables
   logic [`GPC_NEV-1:0] prev_q;            // Last edge-pin level
   logic ack_q;
   logic [31:0] dat_q;
   logic kb6_q, kb2_q, kb7_q, irqd_q;      // Registered sinks

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire logic [7:0] idx = wb_adr_i[9:2];
   wire logic req = wb_cyc_i && wb_stb_i;
   // Writes land on the edge at which the master sees ack
   wire logic wr_en = req && wb_we_i && ack_q && wb_sel_i[0];
   wire logic [7:0] slot_off = idx - `GPC_IDX_P21;
   wire logic hit_cfg = (idx >= `GPC_IDX_P21) && (idx <= `GPC_IDX_P31);
   wire logic [7:0] wdat = wb_dat_i[7:0];
   wire logic [`GPC_NEV-1:0] w1c =
      (wr_en && idx == `GPC_IDX_STAT) ? wdat[`GPC_NEV-1:0] : '0;

   // ------------------------------------------------------------
   // Function decode per slot
   // ------------------------------------------------------------
   wire gpc_pkg::gpc_fn_type f21 = fn2(cfg_q[`GPC_S21]);
   wire gpc_pkg::gpc_fn_type f22 = fn2(cfg_q[`GPC_S22]);
   wire logic a23 = cfg_q[`GPC_S23][`GPC_B_ALT];
   wire logic a24 = cfg_q[`GPC_S24][`GPC_B_ALT];
   wire logic a25 = cfg_q[`GPC_S25][`GPC_B_ALT];
   wire logic a27 = cfg_q[`GPC_S27][`GPC_B_ALT];
   wire logic a30 = cfg_q[`GPC_S30][`GPC_B_ALT];
   wire logic a31 = cfg_q[`GPC_S31][`GPC_B_ALT];
   // Code 11 on pin 2.1 falls back to plain GPIO
   wire logic kb6_sel = (f21 == gpc_pkg::fn_kbc);
   wire logic kb2a_sel = (f22 == gpc_pkg::fn_kbc);
   wire logic mot_sel = (f22 == gpc_pkg::fn_extra);
   wire logic [`GPC_NEV-1:0] edge_sel = {
      f22 == gpc_pkg::fn_edge, f21 == gpc_pkg::fn_edge};

   // ------------------------------------------------------------
   // Alternate drive per slot (input-only functions drive GPIO data)
   // ------------------------------------------------------------
   logic [`GPC_NPIN-1:0] alt_en;
   logic [`GPC_NPIN-1:0] alt_val;
   logic [`GPC_NPIN-1:0] val;
   assign alt_en = {a31, a30, a27, 1'b0, a25, a24, 1'b0,
                    kb2a_sel || mot_sel, kb6_sel};
   assign alt_val = {ext_bus_chip_select_3_i,
                     ext_bus_chip_select_2_i,
                     system_mgmt_interrupt_out_i,
                     1'b0,
                     kbc_port_bit2_i,
                     kbc_port_bit7_i,
                     1'b0,
                     mot_sel ? floppy_motor_select_1_i
                             : kbc_port_bit2_i,
                     kbc_port_bit6_i};

   // ------------------------------------------------------------
   // Pads
   // ------------------------------------------------------------
   for (genvar s = 0; s < `GPC_NPIN; s++) begin : g_pin
      gpc_pin_cell u_cell (
         .cfg_i(cfg_q[s]),
         .alt_en_i(alt_en[s]),
         .alt_val_i(alt_val[s]),
         .gpio_val_i(dout_q[s]),
         .pin_i(pin_i[s]),
         .pin_o(pin_o[s]),
         .pin_oe_o(pin_oe_o[s]),
         .val_o(val[s])
      );
   end

   // ------------------------------------------------------------
   // Events: any change of an edge pin, either direction
   // ------------------------------------------------------------
   wire logic [`GPC_NEV-1:0] ev = edge_sel &
      (val[`GPC_NEV-1:0] ^ prev_q);
   // A new event wins over a clear in the same cycle
   wire logic [`GPC_NEV-1:0] stat_d = (stat_q & ~w1c) | ev;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   logic [7:0] rd;
   always_comb begin
      rd = 8'h00;                        // Unmapped reads as zero
      if (hit_cfg) begin
         rd = cfg_q[slot_off[3:0]];
      end else if (idx == `GPC_IDX_DOUT) begin
         rd = dout_q[7:0];
      end else if (idx == `GPC_IDX_PINS) begin
         rd = val[7:0];
      end else if (idx == `GPC_IDX_STAT) begin
         rd = {6'h00, stat_q};
      end else if (idx == `GPC_IDX_MASK) begin
         rd = {6'h00, mask_q};
      end
   end

   // ------------------------------------------------------------
   // Bus handshake: ack one cycle after request, dropped next
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req && !ack_q;
         if (req && !ack_q) begin
            dat_q <= {24'h00_0000, rd};
         end
      end
   end

   // ------------------------------------------------------------
   // Configuration registers; reserved bits never store
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      for (int s = 0; s < `GPC_NPIN; s++) begin
         if (rst_i) begin
            cfg_q[s] <= `GPC_CFG_RST;
         end else if (wr_en && hit_cfg && slot_off == 8'(s)) begin
            cfg_q[s] <= wdat & wmask(s);
         end
      end
   end

   // ------------------------------------------------------------
   // Data, event and mask registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dout_q <= '0;
         stat_q <= '0;
         mask_q <= '0;
         prev_q <= '0;
      end else begin
         stat_q <= stat_d;
         prev_q <= val[`GPC_NEV-1:0];
         if (wr_en && idx == `GPC_IDX_DOUT) begin
            dout_q <= {dout_q[8], wdat};
         end
         if (wr_en && idx == `GPC_IDX_MASK) begin
            mask_q <= wdat[`GPC_NEV-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Registered sinks toward the core; kbc bits idle high, irq input D idles low when not routed
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         kb6_q <= 1'b1;
         kb2_q <= 1'b1;
         kb7_q <= 1'b1;
         irqd_q <= 1'b0;
      end else begin
         kb6_q <= kb6_sel ? val[`GPC_S21] : 1'b1;
         kb2_q <= kb2a_sel ? val[`GPC_S22] :
                  (a25 ? val[`GPC_S25] : 1'b1);
         kb7_q <= a24 ? val[`GPC_S24] : 1'b1;
         irqd_q <= a23 ? val[`GPC_S23] : 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign kbc_port_bit6_o = kb6_q;
   assign kbc_port_bit2_o = kb2_q;
   assign kbc_port_bit7_o = kb7_q;
   assign irq_input_d_o = irqd_q;
   assign irq_o = |(stat_q & mask_q);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   cfg_reset_a: assert property (@(posedge clk_i)
      $fell(rst_i) |-> cfg_q[`GPC_S21] == `GPC_CFG_RST
                       && cfg_q[`GPC_S31] == `GPC_CFG_RST && pin_oe_o == '0)
      else $error("config not at reset value");
   dir_input_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_q[`GPC_S26][`GPC_B_DIR] |-> !pin_oe_o[`GPC_S26])
      else $error("input pin driven");
   push_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cfg_q[`GPC_S26][`GPC_B_OD] == 1'b0 && !cfg_q[`GPC_S26][`GPC_B_DIR])
      |-> pin_oe_o[`GPC_S26]
          && pin_o[`GPC_S26] == (dout_q[`GPC_S26] ^ cfg_q[`GPC_S26][`GPC_B_POL]))
      else $error("push-pull drive wrong");
   open_drain_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_q[`GPC_S26][`GPC_B_OD] |-> pin_o[`GPC_S26] == 1'b0)
      else $error("open drain drives high");
   edge_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (edge_sel[0] && $changed(val[0]) && !$changed(cfg_q[`GPC_S21]))
      |=> stat_q[0])
      else $error("edge not flagged");
   bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !ack_q) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack timing wrong");
   rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cfg_q[`GPC_S23][6:3] == 4'h0) && (cfg_q[`GPC_S21][6:4] == 3'h0)
      && (cfg_q[`GPC_S26][6:2] == 5'h00))
      else $error("reserved bit stored");
   // A flagged, enabled event keeps the line up until software clears it
   irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (stat_q[0] && mask_q[0] && !w1c[0] && !(wr_en && idx == `GPC_IDX_MASK))
      |=> irq_o)
      else $error("irq level wrong");
   stat_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (w1c[0] && !ev[0]) |=> !stat_q[0])
      else $error("status not cleared");
   cs2_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (a30 && !cfg_q[`GPC_S30][`GPC_B_OD] && !cfg_q[`GPC_S30][`GPC_B_POL])
      |-> pin_o[`GPC_S30] == ext_bus_chip_select_2_i)
      else $error("chip select 2 not routed");
   irqd_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
      a23 ##1 a23 |-> irq_input_d_o == $past(val[`GPC_S23]))
      else $error("irq input D not routed");
endmodule : gpc_port_cfg

// file: gpc_board.sv
`timescale 1ns/1ps
`include "gpc_map.svh"
// ------------------------------------------------------------
// Board side of the nine pads: pull-ups plus optional drivers
// ------------------------------------------------------------
module gpc_board (
   // Pad drive from the port
   input wire logic [`GPC_NPIN-1:0] pin_o,
   input wire logic [`GPC_NPIN-1:0] pin_oe_o,
   // Board drivers, controlled by the bench
   input wire logic [`GPC_NPIN-1:0] ext_en_i,
   input wire logic [`GPC_NPIN-1:0] ext_val_i,
   // Resolved wire level back to the port
   output logic [`GPC_NPIN-1:0] pin_i
);
   // Port drive wins, then a board driver, else the pull-up lifts the wire
   // so a released open-drain pad never reads a stale low
   always_comb begin
      for (int k = 0; k < `GPC_NPIN; k++) begin
         pin_i[k] = pin_oe_o[k] ? pin_o[k] : (ext_en_i[k] ? ext_val_i[k] : 1'b1);
      end
   end
endmodule : gpc_board

// file: tb_gpc_port_cfg.sv
`timescale 1ns/1ps
`include "gpc_map.svh"
module tb_gpc_port_cfg;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clk_i, rst_i, cyc, stb, we;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   logic ack, irq, irqd, k6o, k2o, k7o;
   logic [6:0] alt_v; // kbc6, kbc2, kbc7, motor, smi, cs2, cs3
   logic [8:0] pin_i, pin_o, pin_oe, ext_en, ext_v, e;
   logic [7:0] rv;
   int n_mismatch = 0;
   int num_checks = 0;
   // ------------------------------------------------------------
   // Design, board model, clock
   // ------------------------------------------------------------
   gpc_port_cfg #(.ADR_W(10)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe),
      .kbc_port_bit6_i(alt_v[0]), .kbc_port_bit2_i(alt_v[1]), .kbc_port_bit7_i(alt_v[2]),
      .kbc_port_bit6_o(k6o), .kbc_port_bit2_o(k2o), .kbc_port_bit7_o(k7o),
      .floppy_motor_select_1_i(alt_v[3]), .system_mgmt_interrupt_out_i(alt_v[4]),
      .ext_bus_chip_select_2_i(alt_v[5]), .ext_bus_chip_select_3_i(alt_v[6]),
      .irq_input_d_o(irqd), .irq_o(irq));
   gpc_board brd (.pin_o(pin_o), .pin_oe_o(pin_oe), .ext_en_i(ext_en), .ext_val_i(ext_v),
      .pin_i(pin_i));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One classic cycle; waits for ack, takes read data at that edge
   task automatic wb_xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h0, wd};
      sel <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) chk(16'h0bad, 16'h0000);
      rv = rdat[7:0];
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wb_xfer
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      wb_xfer(1'b0, idx, 8'h00);
      chk({8'h0, rv}, {8'h0, exp});
   endtask : rd_chk
   // Settle a few cycles, then look between edges
   task automatic settle();
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
   endtask : settle
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      close_out();
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; wdat = '0;
      alt_v = '0; ext_en = '0; ext_v = '0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, then all-ones write showing the writable masks
      for (int s = 0; s < 9; s++) rd_chk(8'h2c + s[7:0], 8'h01);
      chk({7'h0, pin_oe}, 16'h0000);
      for (int s = 0; s < 9; s++) begin
         wb_xfer(1'b1, 8'h2c + s[7:0], 8'hff);
         rd_chk(8'h2c + s[7:0], (s < 2) ? 8'h8f : ((s == 5) ? 8'h83 : 8'h87));
      end
      rd_chk(`GPC_IDX_P26, 8'h83);
      wb_xfer(1'b1, 8'h20, 8'h5a);
      rd_chk(8'h20, 8'h00);
      $display("Test registers done");
      // Output type and polarity on pin 2.6
      wb_xfer(1'b1, `GPC_IDX_DOUT, 8'h20);
      wb_xfer(1'b1, `GPC_IDX_P26, 8'h00);
      settle();
      chk({pin_oe[5], pin_o[5]}, 16'h0003);
      wb_xfer(1'b1, `GPC_IDX_P26, 8'h02);
      settle();
      chk({pin_oe[5], pin_o[5]}, 16'h0002);
      wb_xfer(1'b1, `GPC_IDX_P26, 8'h80);
      settle();
      chk(pin_oe[5], 1'b0);
      wb_xfer(1'b1, `GPC_IDX_P26, 8'h82);
      settle();
      chk({pin_oe[5], pin_o[5]}, 16'h0002);
      $display("Test driver done");
      // Alternate outputs; pin 2.1 first on its reserved code, then kbc bit 6
      wb_xfer(1'b1, `GPC_IDX_DOUT, 8'ha5);
      wb_xfer(1'b1, `GPC_IDX_P22, 8'h0c);
      wb_xfer(1'b1, `GPC_IDX_P23, 8'h04);
      wb_xfer(1'b1, `GPC_IDX_P26, 8'h00);
      for (int s = 3; s < 9; s++) if (s != 5) wb_xfer(1'b1, 8'h2c + s[7:0], 8'h04);
      for (int p = 0; p < 4; p++) begin
         wb_xfer(1'b1, `GPC_IDX_P21, p[1] ? 8'h04 : 8'h0c);
         alt_v <= p[0] ? 7'h2a : 7'h55;
         settle();
         e = {alt_v[6], alt_v[5], alt_v[4], 1'b1, alt_v[1], alt_v[2], 1'b1, alt_v[3],
              p[1] ? alt_v[0] : 1'b1};
         chk({7'h0, pin_o}, {7'h0, e});
         chk({7'h0, pin_oe}, 16'h01ff);
      end
      $display("Test alternate outputs done");
      // Alternate inputs from the board
      for (int s = 0; s < 9; s++) wb_xfer(1'b1, 8'h2c + s[7:0], 8'h01);
      wb_xfer(1'b1, `GPC_IDX_P21, 8'h05);
      wb_xfer(1'b1, `GPC_IDX_P23, 8'h07);
      wb_xfer(1'b1, `GPC_IDX_P24, 8'h05);
      wb_xfer(1'b1, `GPC_IDX_P25, 8'h05);
      ext_en <= 9'h1ff;
      for (int p = 0; p < 2; p++) begin
         ext_v <= p[0] ? 9'h0a3 : 9'h15c;
         settle();
         chk({irqd, k7o, k6o, k2o}, {~ext_v[2], ext_v[3], ext_v[0], ext_v[4]});
         rd_chk(`GPC_IDX_PINS, ext_v[7:0] ^ 8'h04);
      end
      wb_xfer(1'b1, `GPC_IDX_P22, 8'h05);
      settle();
      chk(k2o, ext_v[1]);
      wb_xfer(1'b1, `GPC_IDX_P23, 8'h03);
      settle();
      chk(irqd, 1'b0);
      $display("Test alternate inputs done");
      // Either-edge interrupts on pins 2.1 and 2.2
      @(posedge clk_i);
      ext_v <= 9'h000;
      wb_xfer(1'b1, `GPC_IDX_P21, 8'h09);
      wb_xfer(1'b1, `GPC_IDX_P22, 8'h09);
      wb_xfer(1'b1, `GPC_IDX_MASK, 8'h03);
      wb_xfer(1'b1, `GPC_IDX_STAT, 8'h03);
      rd_chk(`GPC_IDX_STAT, 8'h00);
      ext_v <= 9'h001;
      settle();
      rd_chk(`GPC_IDX_STAT, 8'h01);
      chk(irq, 1'b1);
      wb_xfer(1'b1, `GPC_IDX_STAT, 8'h01);
      settle();
      chk(irq, 1'b0);
      @(posedge clk_i);
      ext_v <= 9'h000;
      settle();
      rd_chk(`GPC_IDX_STAT, 8'h01);
      wb_xfer(1'b1, `GPC_IDX_MASK, 8'h02);
      settle();
      chk(irq, 1'b0);
      @(posedge clk_i);
      ext_v <= 9'h002;
      settle();
      rd_chk(`GPC_IDX_STAT, 8'h03);
      chk(irq, 1'b1);
      wb_xfer(1'b1, `GPC_IDX_STAT, 8'h03);
      settle();
      chk(irq, 1'b0);
      $display("Test edge interrupts done");
      close_out();
   end
endmodule : tb_gpc_port_cfg
